// ==== shared/sdram_timing_defines.svh ====
// Timing figures, derived cycle counts and pin codes for the DRAM command timing controller
`ifndef SDRAM_TIMING_DEFINES_SVH
`define SDRAM_TIMING_DEFINES_SVH
// Own clock 25 MHz; memory clock is the own clock divided by two
`define CLK_PS 40000
`define CK_DIV 2
`define CK_PS (`CLK_PS * `CK_DIV)
`define CYC_UP(ps) (((ps) + `CLK_PS - 1) / `CLK_PS)
`define CYC_DN(ps) ((ps) / `CLK_PS)
`define NCK(n) ((n) * `CK_DIV)
`define MAX2(a, b) (((a) > (b)) ? (a) : (b))
// Figures in memory clocks or picoseconds
`define MRD_NCK 4
`define MOD_NCK 12
`define MOD_PS 15000
`define CCD_NCK 4
`define WR_PS 15000
`define MPRR_NCK 1
`define RRD_NCK 4
`define RRD_PS 7500
`define FAW_FAST_PS 40000
`define FAW_SLOW_PS 45000
`define ZQI_NCK 512
`define ZQI_PS 640000
`define ZQO_NCK 256
`define ZQO_PS 320000
`define ZQS_NCK 64
`define ZQS_PS 80000
`define XPR_NCK 5
`define XPR_PS 270000
`define XS_NCK 5
`define XS_PS 270000
`define DLLK_NCK 512
`define CKE_NCK 3
`define CKE_PS 5625
`define CKSR_NCK 5
`define CKSR_PS 10000
`define RFC_PS 260000
`define REFI_PS 7800000
`define REFI_HOT_PS 3900000
`define WTR_NCK 4
`define WTR_PS 7500
// Device settings this controller assumes
`define WL_NCK 5
`define BURST_NCK 4
`define WR_MODE_NCK 5
`define RP_PS 15000
// Timer loads: cycles of spacing minus one
`define WDATA_CYC `NCK(`WL_NCK + `BURST_NCK)
`define MRD_LD (`NCK(`MRD_NCK) - 1)
`define MOD_LD (`MAX2(`NCK(`MOD_NCK), `CYC_UP(`MOD_PS)) - 1)
`define CCD_LD (`NCK(`CCD_NCK) - 1)
`define WR_LD (`WDATA_CYC + `CYC_UP(`WR_PS) - 1)
`define DAL_LD (`NCK(`WL_NCK + `BURST_NCK + `WR_MODE_NCK + (`RP_PS + `CK_PS - 1) / `CK_PS) - 1)
`define MPRR_LD (`NCK(`MPRR_NCK) - 1)
`define RRD_LD (`MAX2(`NCK(`RRD_NCK), `CYC_UP(`RRD_PS)) - 1)
`define FAW_LD (`CYC_UP(`MAX2(`FAW_FAST_PS, `FAW_SLOW_PS)) - 1)
`define ZQI_LD (`MAX2(`NCK(`ZQI_NCK), `CYC_UP(`ZQI_PS)) - 1)
`define ZQO_LD (`MAX2(`NCK(`ZQO_NCK), `CYC_UP(`ZQO_PS)) - 1)
`define ZQS_LD (`MAX2(`NCK(`ZQS_NCK), `CYC_UP(`ZQS_PS)) - 1)
`define XPR_LD (`MAX2(`NCK(`XPR_NCK), `CYC_UP(`XPR_PS)) - 1)
`define XS_LD (`MAX2(`NCK(`XS_NCK), `CYC_UP(`XS_PS)) - 1)
`define XSDLL_LD (`NCK(`DLLK_NCK) - 1)
`define CKESR_CYC (`MAX2(`NCK(`CKE_NCK), `CYC_UP(`CKE_PS)) + `NCK(1))
`define SRW_LD (`MAX2(`CKESR_CYC, `MAX2(`NCK(`CKSR_NCK), `CYC_UP(`CKSR_PS))) - 1)
`define RFC_LD (`CYC_UP(`RFC_PS) - 1)
`define WTR_LD (`WDATA_CYC + `MAX2(`NCK(`WTR_NCK), `CYC_UP(`WTR_PS)) - 1)
`define REFI_CYC `CYC_DN(`REFI_PS)
`define REFI_HOT_CYC `CYC_DN(`REFI_HOT_PS)
// Pin codes {cs_n, ras_n, cas_n, we_n}
`define CMD_MRS 4'h0
`define CMD_REF 4'h1
`define CMD_PRE 4'h2
`define CMD_ACT 4'h3
`define CMD_WR 4'h4
`define CMD_RD 4'h5
`define CMD_ZQ 4'h6
`define CMD_NOP 4'h7
`endif

// ==== shared/sdram_timing_pkg.sv ====
// Types for the DRAM command timing controller
`default_nettype none
package sdram_timing_pkg;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_MRS = 4'h1, OP_MPRX = 4'h2, OP_REF = 4'h3, OP_PRE = 4'h4,
    OP_ACT = 4'h5, OP_WR = 4'h6, OP_WRA = 4'h7, OP_RD = 4'h8, OP_ZQCL = 4'h9,
    OP_ZQCS = 4'hA, OP_SRE = 4'hB, OP_SRX = 4'hC
  } op_e;
  typedef struct packed {
    op_e op;
    logic [2:0] bank;
    logic [14:0] addr;
  } req_s;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } pin_cmd_s;
  typedef enum logic [3:0] {
    ST_RST = 4'h1, ST_CKE = 4'h2, ST_RUN = 4'h4, ST_SELF = 4'h8
  } phase_e;
  typedef enum int {
    T_MRD, T_MOD, T_CCD, T_WR, T_DAL, T_MPRR, T_RRD,
    T_ZQ, T_XPR, T_XS, T_XSDLL, T_SRW, T_RFC, T_WTR
  } tmr_e;
endpackage : sdram_timing_pkg
`default_nettype wire

// ==== hw/sdram_command_timing.sv ====
// Host controller that issues DRAM commands while keeping their minimum spacings
`timescale 1ns/100ps
`default_nettype none
`include "sdram_timing_defines.svh"
module sdram_command_timing
  import sdram_timing_pkg::*;
#(
  parameter int RESET_HOLD_CYCLES = 5000
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire req_s req,
  input wire logic hot,
  output logic req_done,
  output logic init_done,
  output logic refresh_due,
  output logic ck,
  output logic ck_n,
  output logic cke,
  output logic mem_reset_n,
  output pin_cmd_s cmd,
  output logic [2:0] ba,
  output logic [14:0] addr
);
  localparam int NT = 18;
  localparam int FAW0 = 14;
  localparam int HW = 13;

  logic [2:0] hot_sync, next_hot_sync;
  logic hot_level, next_hot_level;
  logic [7:0] since_mrs, next_since_mrs;
  logic [7:0] since_wr, next_since_wr;

  phase_e phase, next_phase;
  logic [HW-1:0] hold, next_hold;
  logic [11:0] tmr [NT];
  logic [11:0] next_tmr [NT];
  logic [11:0] tmr_dec [NT];
  logic [1:0] faw_ptr, next_faw_ptr;
  logic [7:0] refi, next_refi;
  logic [7:0] refi_lim;
  logic zq_first, next_zq_first;
  logic next_ck, next_ck_n, next_cke, next_mem_reset_n;
  logic next_req_done, next_init_done, next_refresh_due;
  pin_cmd_s next_cmd;
  logic [2:0] next_ba;
  logic [14:0] next_addr;
  logic ok, take, mod_free, blk_all;
  logic is_mrs, is_col, is_act, is_ref, is_other;

  // Temperature flag crosses in; a change counts once two stages agree
  always_comb begin
    next_hot_sync = {hot_sync[1:0], hot};
    next_hot_level = (hot_sync[1] == hot_sync[2]) ? hot_sync[2] : hot_level;
    next_since_mrs = (since_mrs == 8'hFF) ? since_mrs : since_mrs + 8'h01;
    next_since_wr = (since_wr == 8'hFF) ? since_wr : since_wr + 8'h01;
    if (is_mrs) begin
      next_since_mrs = 8'h00;
    end
    if (req_done && cmd == pin_cmd_s'(`CMD_WR)) begin
      next_since_wr = 8'h00;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hot_sync <= 3'h0;
      hot_level <= 1'b0;
      since_mrs <= 8'hFF;
      since_wr <= 8'hFF;
    end else begin
      hot_sync <= next_hot_sync;
      hot_level <= next_hot_level;
      since_mrs <= next_since_mrs;
      since_wr <= next_since_wr;
    end
  end

  // Every spacing is a down-counter; zero means the window is closed
  for (genvar i = 0; i < NT; i++) begin : g_dec
    assign tmr_dec[i] = (tmr[i] == 12'h000) ? 12'h000 : tmr[i] - 12'h001;
  end

  always_comb begin
    next_tmr = tmr_dec;
    next_phase = phase;
    next_hold = hold;
    next_faw_ptr = faw_ptr;
    next_zq_first = zq_first;
    next_ck = ~ck;
    next_ck_n = ck;
    next_cke = cke;
    next_mem_reset_n = mem_reset_n;
    next_cmd = cmd;
    next_ba = ba;
    next_addr = addr;
    next_req_done = 1'b0;
    next_init_done = init_done | (phase == ST_RUN && tmr[T_XPR] == 12'h000);
    next_refi = refi;
    refi_lim = hot_level ? 8'(`REFI_HOT_CYC) : 8'(`REFI_CYC);
    mod_free = tmr[T_MOD] == 12'h000;
    // Calibration, reset exit, special register exit and self-refresh exit hold off all
    blk_all = (tmr[T_ZQ] | tmr[T_XPR] | tmr[T_MPRR] | tmr[T_XS])
      != 12'h000;
    case (req.op)
      OP_MRS, OP_MPRX: ok = tmr[T_MRD] == 12'h000;
      OP_REF: ok = mod_free && tmr[T_RFC] == 12'h000;
      OP_PRE: ok = mod_free && tmr[T_WR] == 12'h000;
      OP_ACT: ok = mod_free && (tmr[T_RRD] | tmr[T_DAL] | tmr[T_RFC]) == 12'h000
        && tmr[FAW0 + int'(faw_ptr)] == 12'h000;
      OP_WR, OP_WRA: ok = mod_free && tmr[T_CCD] == 12'h000;
      OP_RD: ok = mod_free && (tmr[T_CCD] | tmr[T_WTR] | tmr[T_XSDLL]) == 12'h000;
      OP_ZQCL, OP_ZQCS, OP_SRE: ok = mod_free;
      // Clock is free-running, so it is valid around both ends of self-refresh
      OP_SRX: ok = tmr[T_SRW] == 12'h000;
      default: ok = 1'b0;
    endcase
    take = 1'b0;
    case (phase)
      ST_RST: begin
        next_hold = hold + 13'h0001;
        if (hold == HW'(RESET_HOLD_CYCLES)) begin
          next_mem_reset_n = 1'b1;
          next_hold = '0;
          next_phase = ST_CKE;
        end
      end
      ST_CKE: begin
        next_hold = hold + 13'h0001;
        if (hold == HW'(RESET_HOLD_CYCLES)) begin
          next_cke = 1'b1;
          next_tmr[T_XPR] = 12'(`XPR_LD);
          next_zq_first = 1'b1;
          next_phase = ST_RUN;
        end
      end
      ST_RUN: begin
        // The user still holds the request during the req_done pulse
        take = ck && req_valid && !req_done && !blk_all && ok && req.op != OP_SRX;
        next_refi = (refi == refi_lim - 8'h01) ? 8'h00 : refi + 8'h01;
      end
      ST_SELF: begin
        take = ck && req_valid && !req_done && ok && req.op == OP_SRX;
      end
      default: begin
        next_phase = ST_RST;
      end
    endcase
    // Commands change only ahead of a rising memory clock and last one memory clock
    if (ck) begin
      next_cmd = pin_cmd_s'(`CMD_NOP);
    end
    if (take) begin
      next_req_done = 1'b1;
      next_ba = req.bank;
      next_addr = req.addr;
      case (req.op)
        OP_MRS: begin
          next_cmd = pin_cmd_s'(`CMD_MRS);
          next_tmr[T_MRD] = 12'(`MRD_LD);
          next_tmr[T_MOD] = 12'(`MOD_LD);
        end
        OP_MPRX: begin
          next_cmd = pin_cmd_s'(`CMD_MRS);
          next_tmr[T_MRD] = 12'(`MRD_LD);
          next_tmr[T_MOD] = 12'(`MOD_LD);
          next_tmr[T_MPRR] = 12'(`MPRR_LD);
        end
        OP_REF: begin
          next_cmd = pin_cmd_s'(`CMD_REF);
          next_tmr[T_RFC] = 12'(`RFC_LD);
        end
        OP_PRE: begin
          next_cmd = pin_cmd_s'(`CMD_PRE);
        end
        OP_ACT: begin
          next_cmd = pin_cmd_s'(`CMD_ACT);
          next_tmr[T_RRD] = 12'(`RRD_LD);
          next_tmr[FAW0 + int'(faw_ptr)] = 12'(`FAW_LD);
          next_faw_ptr = faw_ptr + 2'h1;
        end
        OP_WR, OP_WRA: begin
          next_cmd = pin_cmd_s'(`CMD_WR);
          next_addr[10] = req.op == OP_WRA;
          next_tmr[T_CCD] = 12'(`CCD_LD);
          next_tmr[T_WR] = 12'(`WR_LD);
          next_tmr[T_WTR] = 12'(`WTR_LD);
          if (req.op == OP_WRA) begin
            next_tmr[T_DAL] = 12'(`DAL_LD);
          end
        end
        OP_RD: begin
          next_cmd = pin_cmd_s'(`CMD_RD);
          next_tmr[T_CCD] = 12'(`CCD_LD);
        end
        OP_ZQCL: begin
          next_cmd = pin_cmd_s'(`CMD_ZQ);
          next_addr[10] = 1'b1;
          next_tmr[T_ZQ] = zq_first ? 12'(`ZQI_LD) : 12'(`ZQO_LD);
          next_zq_first = 1'b0;
        end
        OP_ZQCS: begin
          next_cmd = pin_cmd_s'(`CMD_ZQ);
          next_addr[10] = 1'b0;
          next_tmr[T_ZQ] = 12'(`ZQS_LD);
        end
        OP_SRE: begin
          next_cmd = pin_cmd_s'(`CMD_REF);
          next_cke = 1'b0;
          next_tmr[T_SRW] = 12'(`SRW_LD);
          next_phase = ST_SELF;
        end
        OP_SRX: begin
          next_cmd = pin_cmd_s'(`CMD_NOP);
          next_cke = 1'b1;
          next_tmr[T_XS] = 12'(`XS_LD);
          next_tmr[T_XSDLL] = 12'(`XSDLL_LD);
          next_phase = ST_RUN;
        end
        default: begin
          next_cmd = pin_cmd_s'(`CMD_NOP);
        end
      endcase
    end
    // A refresh taken in the same cycle as a new tick leaves the flag set
    next_refresh_due = (phase == ST_RUN && refi == refi_lim - 8'h01)
      | (refresh_due & ~(take && req.op == OP_REF));
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase <= ST_RST;
      hold <= '0;
      for (int i = 0; i < NT; i++) begin
        tmr[i] <= 12'h000;
      end
      faw_ptr <= 2'h0;
      refi <= 8'h00;
      zq_first <= 1'b1;
      ck <= 1'b0;
      ck_n <= 1'b1;
      cke <= 1'b0;
      mem_reset_n <= 1'b0;
      cmd <= pin_cmd_s'(`CMD_NOP);
      ba <= 3'h0;
      addr <= 15'h0000;
      req_done <= 1'b0;
      init_done <= 1'b0;
      refresh_due <= 1'b0;
    end else begin
      phase <= next_phase;
      hold <= next_hold;
      tmr <= next_tmr;
      faw_ptr <= next_faw_ptr;
      refi <= next_refi;
      zq_first <= next_zq_first;
      ck <= next_ck;
      ck_n <= next_ck_n;
      cke <= next_cke;
      mem_reset_n <= next_mem_reset_n;
      cmd <= next_cmd;
      ba <= next_ba;
      addr <= next_addr;
      req_done <= next_req_done;
      init_done <= next_init_done;
      refresh_due <= next_refresh_due;
    end
  end

  assign is_mrs = req_done && cmd == pin_cmd_s'(`CMD_MRS);
  assign is_col = req_done && (cmd == pin_cmd_s'(`CMD_WR) || cmd == pin_cmd_s'(`CMD_RD));
  assign is_act = req_done && cmd == pin_cmd_s'(`CMD_ACT);
  assign is_ref = req_done && cmd == pin_cmd_s'(`CMD_REF);
  assign is_other = req_done && cmd != pin_cmd_s'(`CMD_MRS) && cmd != pin_cmd_s'(`CMD_NOP);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  mrs_spacing_a: assert property (is_mrs |=> !is_mrs [*7])
    else $error("mode register sets too close");
  mode_update_a: assert property (is_other |-> since_mrs >= 8'd23)
    else $error("command too soon after mode register set");
  col_spacing_a: assert property (is_col |=> !is_col [*7])
    else $error("column commands too close");
  act_spacing_a: assert property (is_act |=> !is_act [*7])
    else $error("activates too close");
  refresh_cycle_a: assert property (is_ref && cke |=> !(is_act || is_ref) [*6])
    else $error("activate or refresh inside refresh cycle");
  write_recovery_a: assert property (
    req_done && cmd == pin_cmd_s'(`CMD_PRE) |-> since_wr >= 8'd18)
    else $error("precharge inside write recovery");
  write_read_a: assert property (
    req_done && cmd == pin_cmd_s'(`CMD_RD) |-> since_wr >= 8'd25)
    else $error("read too soon after write");
  short_cal_a: assert property (
    req_done && cmd == pin_cmd_s'(`CMD_ZQ) && !addr[10] |-> tmr[T_ZQ] == 12'd127)
    else $error("short calibration window wrong");
  reset_exit_a: assert property (
    $rose(cke) && !req_done |-> !req_done [*8] ##1 !req_done ##1 !req_done)
    else $error("command too soon after reset exit");
  sr_exit_a: assert property (
    $rose(cke) && req_done |=> !req_done [*8] ##1 !req_done)
    else $error("command too soon after self-refresh exit");
endmodule : sdram_command_timing
`default_nettype wire

// ==== verif/sdram_device_model.sv ====
// Behavioural memory device that counts command spacing faults on its pins
`timescale 1ns/100ps
`default_nettype none
module sdram_device_model
  import sdram_timing_pkg::*;
#(
  parameter real TCK_NS = 80.0
) (
  input wire logic ck,
  input wire logic cke,
  input wire logic mem_reset_n,
  input wire pin_cmd_s cmd,
  input wire logic [14:0] addr,
  output int fault_count
);
  realtime now, t_cke = 0, t_low = 0, t_mrs = -1.0e6, t_ref = -1.0e6;
  realtime mod_end = 0, busy_end = 0;
  logic cke_was = 1'b0;
  logic zq_first = 1'b1;
  initial fault_count = 0;
  function automatic realtime mx(input real nck, input real ns);
    return (nck * TCK_NS > ns) ? nck * TCK_NS : ns;
  endfunction : mx
  // Sampled at the memory clock's rising edge; a stopped clock is not modelled
  always @(posedge ck) begin
    // Pins settle after the edge that launched them
    #1;
    now = $realtime;
    if (!mem_reset_n) zq_first = 1'b1;
    if (cke && !cke_was) begin
      if (now - t_low < mx(3, 5.625) + TCK_NS) fault_count++;
      t_cke = now;
    end
    if (!cke && cke_was) t_low = now;
    cke_was = cke;
    if (cmd !== 4'h7 && mem_reset_n) begin
      if (now - t_cke < mx(5, 270)) fault_count++;
      if (now < busy_end) fault_count++;
      if (cmd === 4'h0) begin
        if (now - t_mrs < 4 * TCK_NS) fault_count++;
        t_mrs = now;
        mod_end = now + mx(12, 15);
      end else if (now < mod_end) fault_count++;
      if (cmd inside {4'h1, 4'h3} && now - t_ref < 260) fault_count++;
      if (cmd === 4'h1) t_ref = now;
      if (cmd === 4'h6) begin
        busy_end = now + (zq_first ? mx(512, 640) : addr[10] ? mx(256, 320) : mx(64, 80));
        zq_first = 1'b0;
      end
    end
  end
endmodule : sdram_device_model
`default_nettype wire

// ==== verif/test_sdram_command_timing.sv ====
// Self-checking bench for the DRAM command timing controller
`timescale 1ns/100ps
`default_nettype none
`define CHECK(what, exp, got) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("wrong value %s expected %0h seen %0h", what, exp, got); \
  end \
end
module test_sdram_command_timing;
  import sdram_timing_pkg::*;
  logic clock, rst_n, req_valid, hot, req_done, init_done, refresh_due;
  logic ck, ck_n, cke, mem_reset_n;
  req_s req;
  pin_cmd_s cmd;
  logic [2:0] ba;
  logic [14:0] addr;
  int err_count = 0, n_checks = 0, cyc = 0, t_prev = 0, fault_count;
  // Assumed write data end: write latency 5 plus burst 4 memory clocks
  localparam int WDATA = 2 * (5 + 4);
  sdram_command_timing #(.RESET_HOLD_CYCLES(8)) DUT (
    .clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req(req), .hot(hot),
    .req_done(req_done), .init_done(init_done), .refresh_due(refresh_due), .ck(ck),
    .ck_n(ck_n), .cke(cke), .mem_reset_n(mem_reset_n), .cmd(cmd), .ba(ba), .addr(addr)
  );
  sdram_device_model dev (
    .ck(ck), .cke(cke), .mem_reset_n(mem_reset_n), .cmd(cmd), .addr(addr),
    .fault_count(fault_count)
  );
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;
  // Larger of memory clocks (two cycles each) and a time rounded up to whole cycles
  function automatic int span(input int nck, input int ps);
    int c;
    c = (ps + 39999) / 40000;
    return (2 * nck > c) ? 2 * nck : c;
  endfunction : span
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // Holds the request until taken, then judges spacing from the previous take and the pins
  task automatic issue(input op_e op, input int min_gap);
    int n;
    logic [3:0] code;
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{op: op, bank: 3'h1, addr: 15'h0123};
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (req_done !== 1'b1 && n < 3000);
    case (op)
      OP_MRS, OP_MPRX: code = 4'h0;
      OP_REF, OP_SRE: code = 4'h1;
      OP_PRE: code = 4'h2;
      OP_ACT: code = 4'h3;
      OP_WR, OP_WRA: code = 4'h4;
      OP_RD: code = 4'h5;
      OP_ZQCL, OP_ZQCS: code = 4'h6;
      default: code = 4'h7;
    endcase
    `CHECK("request taken", 1'b1, req_done)
    `CHECK("spacing met", 1'b1, cyc - t_prev >= min_gap)
    if (op != OP_SRX) `CHECK("pin command", code, cmd)
    if (op inside {OP_WR, OP_WRA, OP_ZQCL, OP_ZQCS})
      `CHECK("addr bit 10", op inside {OP_WRA, OP_ZQCL}, addr[10])
    `CHECK("bank", 3'h1, ba)
    t_prev = cyc;
    @(posedge clock);
    req_valid <= 1'b0;
  endtask : issue
  task automatic t_reset;
    repeat (5) @(posedge clock);
    #1;
    `CHECK("reset pins", 8'h70, {cmd, cke, mem_reset_n, ck, req_done})
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
  endtask : t_reset
  task automatic t_init;
    int n;
    n = 0;
    while (cke !== 1'b1 && n < 200) begin
      @(posedge clock);
      #1;
      n++;
    end
    t_prev = cyc;
    issue(OP_ZQCL, 10);
    issue(OP_MRS, span(512, 640000));
    `CHECK("init done", 1'b1, init_done)
  endtask : t_init
  task automatic t_mode;
    issue(OP_MRS, span(4, 0));
    issue(OP_ACT, span(12, 15000));
    repeat (3) issue(OP_ACT, span(4, 7500));
    issue(OP_MPRX, 0);
    issue(OP_PRE, span(1, 0));
  endtask : t_mode
  task automatic t_write;
    issue(OP_ACT, 0);
    issue(OP_WR, 0);
    issue(OP_WR, span(4, 0));
    issue(OP_RD, WDATA + span(4, 7500));
    issue(OP_WR, span(4, 0));
    issue(OP_PRE, WDATA + span(0, 15000));
    issue(OP_ACT, 0);
    issue(OP_WRA, 0);
    issue(OP_ACT, 2 * (5 + 4 + 5 + (15000 + 79999) / 80000));
  endtask : t_write
  task automatic t_calib;
    issue(OP_PRE, 0);
    issue(OP_ZQCL, 0);
    issue(OP_ACT, span(256, 320000));
    issue(OP_PRE, 0);
    issue(OP_ZQCS, 0);
    issue(OP_ACT, span(64, 80000));
    issue(OP_PRE, 0);
  endtask : t_calib
  task automatic t_refresh;
    issue(OP_REF, 0);
    issue(OP_REF, span(0, 260000));
    issue(OP_ACT, span(0, 260000));
    issue(OP_PRE, 0);
  endtask : t_refresh
  task automatic t_selfref;
    issue(OP_SRE, 0);
    `CHECK("cke in self refresh", 1'b0, cke)
    issue(OP_SRX, span(5, 10000));
    `CHECK("cke after exit", 1'b1, cke)
    issue(OP_ACT, span(5, 270000));
    issue(OP_PRE, 0);
    issue(OP_SRE, 0);
    issue(OP_SRX, 0);
    issue(OP_RD, 2 * 512);
  endtask : t_selfref
  task automatic wait_due;
    int n;
    n = 0;
    while (refresh_due !== 1'b1 && n < 1000) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask : wait_due
  // Measures a whole interval after the temperature input has settled
  task automatic t_refi(input logic warm, input int interval);
    int t0;
    hot <= warm;
    wait_due;
    issue(OP_REF, 0);
    wait_due;
    t0 = cyc;
    issue(OP_REF, 0);
    wait_due;
    `CHECK("refresh interval", interval, cyc - t0)
  endtask : t_refi
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    hot = 1'b0;
    t_reset;
    t_init;
    t_mode;
    t_write;
    t_calib;
    t_refresh;
    t_selfref;
    t_refi(1'b0, 7800000 / 40000);
    t_refi(1'b1, 3900000 / 40000);
    `CHECK("device faults", 0, fault_count)
    give_verdict;
  end
  initial begin
    #(40 * 20000);
    err_count++;
    give_verdict;
  end
endmodule : test_sdram_command_timing
`default_nettype wire
